// file: verilog/lms_pkg.sv
package lms_pkg;

  // ****************************************************************
  // command opcodes
  // ****************************************************************
  localparam logic [7:0] OP_SCROLL_CTRL  = 8'h20;
  localparam logic [7:0] OP_SCROLL_SPEED = 8'h21;
  localparam logic [7:0] OP_MODE_CTRL    = 8'h38;
  localparam logic [7:0] OP_COM_MASK     = 8'h41;
  localparam logic [7:0] OP_ROW_MASK     = 8'h42;
  localparam logic [7:0] OP_READ_FLAG    = 8'h70;

  // ****************************************************************
  // reset values and don't-care masks
  // ****************************************************************
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [7:0]  SCROLL_RESET     = 8'h00;
  localparam logic [7:0]  SPEED_RESET      = 8'h00;
  localparam logic [7:0]  COM_MASK_RESET   = 8'h00;
  localparam logic [27:0] ROW_MASK_RESET   = 28'h0000000;
  localparam logic [7:0]  MODE_CARE        = 8'hdf;
  localparam logic [7:0]  SCROLL_CARE      = 8'hb3;
  localparam logic [3:0]  ROW_LOW_CARE     = 4'hf;
  localparam logic [7:0]  READ_FIRST_BYTE  = 8'h00;

  // ****************************************************************
  // field positions inside the parameter bytes
  // ****************************************************************
  localparam int SPEED_V_MSB = 7;
  localparam int SPEED_V_LSB = 4;
  localparam int SPEED_H_MSB = 3;
  localparam int SPEED_H_LSB = 0;
  localparam int ROW_B0_LSB  = 20;
  localparam int ROW_B1_LSB  = 12;
  localparam int ROW_B2_LSB  = 4;
  localparam int FLAG_OT_BIT = 0;
  localparam int FLAG_C0_BIT = 1;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam logic [12:0] COM_PERIOD_TICKS = 13'd4160;
  localparam logic [3:0]  FRAME_UNIT_LAST  = 4'hf;
  localparam logic [4:0]  ROW_POS_LAST     = 5'd27;
  localparam logic [2:0]  PARAM_IDX_LAST   = 3'd7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic thermal_guard_enable;
    logic thermal_auto_select;
    logic ignored;
    logic universal_segment_enable;
    logic matrix_mask_enable;
    logic universal_common_enable;
    logic group_blink_enable;
    logic fade_enable;
  } lms_mode_s;

  typedef struct packed {
    logic       scroll_enable;
    logic       ignored6;
    logic       vertical_scroll_enable;
    logic       horizontal_scroll_enable;
    logic [1:0] ignored32;
    logic       scroll_down_select;
    logic       scroll_left_select;
  } lms_scroll_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] index;
    logic [7:0] data;
  } lms_link_wr_s;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'b001,
    LK_PARAM = 3'b010,
    LK_READ  = 3'b100
  } lms_link_state_e;

endpackage : lms_pkg

// file: verilog/lms_mode_scroll_ctrl.sv
// Summary of operation
// RL1: 38h byte: thermal, universal, mask, blink, fade enables; bit5 ignored.
// RL2: mode, common and row masks take effect at the next frame start.
// RL3: guard+auto: over 150C blank display, direct switches, until below 125C.
// RL4: guard without auto: only the over-temperature flag follows temperature.
// RL5: in user mode the host reads the flag and switches display itself.
// RL6: scroll enable disables universal common and segment functions.
// RL7: binary mode disables matrix masking and fade.
// RL8: group blink enable bit turns group blink or fade effect on.
// RL9: 20h byte: scroll enable, vertical, horizontal, direction bits.
// RL10: each scroll step shifts the image by exactly one position.
// RL11: down select 0 up, 1 down; left select 0 right, 1 left.
// RL12: 21h: nibbles give interval of (code+1)*16 frames, vertical high.
// RL13: a frame lasts active scan count times 4160 oscillator periods.
// RL14: host should avoid fade and cascade while scrolling.
// RL15: opcode 41h plus one byte: bit n enables common output n.
// RL16: the common mask never changes the common scan sequence or timing.
// RL17: opcode 42h plus four bytes: rows 27..20, 19..12, 11..4, 3..0.
// RL18: row bit 1 enables that row; display memory is untouched.
// RL19: a dot lights only where its common and its row are enabled.
// RL20: 70h reads zero byte, then flags: over-temp bit0, first common bit1.
// RL21: don't-care parameter bits are accepted and have no effect.
`timescale 1ns/1ns
`default_nettype none
module lms_mode_scroll_ctrl
  import lms_pkg::*;
(
  // core clock, reset, clock enable
  input  wire  logic        clk_i,
  input  wire  logic        reset_n_i,
  input  wire  logic        ce_i,
  // serial link side, on the link clock
  input  wire  logic        link_clk_i,
  input  wire  logic        link_start_i,
  input  wire  logic        link_byte_valid_i,
  input  wire  logic [7:0]  link_byte_i,
  input  wire  logic        link_rd_ack_i,
  output logic        [7:0] link_rd_data_o,
  output logic              link_rd_valid_o,
  // timing and display state from the core
  input  wire  logic        sys_tick_i,
  input  wire  logic [2:0]  scan_last_i,
  input  wire  logic        binary_mode_i,
  // temperature comparators, asynchronous
  input  wire  logic        temp_hot_i,
  input  wire  logic        temp_cool_i,
  // thermal outputs
  output logic              over_temperature_flag_o,
  output logic              display_blank_o,
  output logic              direct_switch_off_o,
  // scan and window outputs
  output logic              frame_start_o,
  output logic              first_common_scan_flag_o,
  output logic        [7:0] com_drive_o,
  output logic        [27:0] row_enable_o,
  // effective function switches
  output logic              universal_common_function_active_o,
  output logic              universal_segment_function_active_o,
  output logic              mask_active_o,
  output logic              fade_active_o,
  output logic              group_blink_o,
  // scrolling
  output logic              h_step_o,
  output logic              v_step_o,
  output logic        [4:0] h_pos_o,
  output logic        [2:0] v_pos_o,
  output logic              scroll_down_select_o,
  output logic              scroll_left_select_o
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // last frame count of an interval: (code+1)*16-1
  function automatic logic [7:0] frames_last(input logic [3:0] code);
    frames_last = {code, FRAME_UNIT_LAST};
  endfunction : frames_last

  // one-position step on the 28-row axis, wrapping at both ends
  function automatic logic [4:0] row_step(input logic [4:0] pos,
                                          input logic       left);
    if (left) begin
      row_step = (pos == 5'd0) ? ROW_POS_LAST : pos - 5'd1;
    end else begin
      row_step = (pos == ROW_POS_LAST) ? 5'd0 : pos + 5'd1;
    end
  endfunction : row_step

  // ****************************************************************
  // link domain: command parser
  // ****************************************************************
  lms_link_state_e link_state;
  lms_link_wr_s    link_word;
  logic            link_tgl;
  logic [7:0]      link_op;
  logic [2:0]      param_idx;
  logic [1:0]      flag_s1;
  logic [1:0]      flag_s2;

  // opcode byte opens a command, later bytes are parameters
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_state <= LK_IDLE;
      link_op    <= 8'h00;
      param_idx  <= 3'd0;
      link_word  <= '0;
      link_tgl   <= 1'b0;
    end else if (link_byte_valid_i) begin
      if (link_start_i) begin
        link_op   <= link_byte_i;
        param_idx <= 3'd0;
        link_state <= (link_byte_i == OP_READ_FLAG) ? LK_READ : LK_PARAM;
      end else begin
        case (link_state)
          LK_PARAM: begin
            // word is held until the next byte, far longer than the sync
            link_word <= '{opcode: link_op, index: param_idx,
                           data: link_byte_i};
            link_tgl  <= ~link_tgl;
            if (param_idx != PARAM_IDX_LAST) begin
              param_idx <= param_idx + 3'd1;
            end
          end
          LK_READ: link_state <= LK_READ;
          LK_IDLE: link_state <= LK_IDLE;
          default: link_state <= LK_IDLE;
        endcase
      end
    end
  end

  // flags cross into the link domain as levels
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_s1 <= 2'b00;
      flag_s2 <= 2'b00;
    end else begin
      flag_s1 <= {first_common_scan_flag_o, over_temperature_flag_o};
      flag_s2 <= flag_s1;
    end
  end

  // read answer: a zero byte, then the flag byte on each ack
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_rd_data_o  <= READ_FIRST_BYTE;
      link_rd_valid_o <= 1'b0;
    end else if (link_byte_valid_i && link_start_i) begin
      link_rd_data_o  <= READ_FIRST_BYTE; // [RL20]
      link_rd_valid_o <= (link_byte_i == OP_READ_FLAG);
    end else if (link_state == LK_READ && link_rd_ack_i) begin
      link_rd_data_o              <= 8'h00;
      link_rd_data_o[FLAG_OT_BIT] <= flag_s2[0]; // [RL20]
      link_rd_data_o[FLAG_C0_BIT] <= flag_s2[1];
    end else if (link_state != LK_READ) begin
      link_rd_valid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // core domain: receive command words
  // ****************************************************************
  logic         tgl_s1;
  logic         tgl_s2;
  logic         tgl_s3;
  logic         wr_seen;
  lms_link_wr_s wr_word;

  // toggle crossing; the edge detector compares the second and third stages
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (ce_i) begin
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign wr_seen = ce_i && (tgl_s2 != tgl_s3);
  assign wr_word = link_word;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  lms_mode_s   mode_pend;
  lms_mode_s   mode_act;
  lms_scroll_s scroll_ctrl;
  logic [7:0]  scroll_speed;
  logic [7:0]  com_pend;
  logic [7:0]  com_act;
  logic [27:0] row_pend;
  logic [27:0] row_act;
  logic        frame_start;

  // pending mode and mask copies, and the live scroll registers, written straight from the link
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_pend    <= MODE_RESET;
      scroll_ctrl  <= SCROLL_RESET;
      scroll_speed <= SPEED_RESET;
      com_pend     <= COM_MASK_RESET;
      row_pend     <= ROW_MASK_RESET;
    end else if (wr_seen) begin
      case (wr_word.opcode)
        OP_MODE_CTRL: begin
          if (wr_word.index == 3'd0) begin
            mode_pend <= wr_word.data & MODE_CARE; // [RL1] [RL21]
          end
        end
        OP_SCROLL_CTRL: begin
          if (wr_word.index == 3'd0) begin
            scroll_ctrl <= wr_word.data & SCROLL_CARE; // [RL9] [RL21]
          end
        end
        OP_SCROLL_SPEED: begin
          if (wr_word.index == 3'd0) begin
            scroll_speed <= wr_word.data; // [RL12]
          end
        end
        OP_COM_MASK: begin
          if (wr_word.index == 3'd0) begin
            com_pend <= wr_word.data; // [RL15]
          end
        end
        OP_ROW_MASK: begin
          // four bytes, highest rows first [RL17]
          case (wr_word.index)
            3'd0: row_pend[ROW_B0_LSB +: 8] <= wr_word.data;
            3'd1: row_pend[ROW_B1_LSB +: 8] <= wr_word.data;
            3'd2: row_pend[ROW_B2_LSB +: 8] <= wr_word.data;
            3'd3: row_pend[3:0] <= wr_word.data[3:0] & ROW_LOW_CARE;
            default: row_pend <= row_pend; // extra bytes ignored
          endcase
        end
        default: mode_pend <= mode_pend; // other opcodes not ours
      endcase
    end
  end

  // active copies change only at the start of a frame
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_act <= MODE_RESET;
      com_act  <= COM_MASK_RESET;
      row_act  <= ROW_MASK_RESET;
    end else if (ce_i && frame_start) begin
      mode_act <= mode_pend; // [RL2]
      com_act  <= com_pend;  // [RL2]
      row_act  <= row_pend;  // [RL2]
    end
  end

  // ****************************************************************
  // frame and common scan timing
  // ****************************************************************
  logic [12:0] tick_cnt;
  logic [2:0]  com_idx;
  logic        com_end;

  assign com_end     = sys_tick_i && (tick_cnt == COM_PERIOD_TICKS - 13'd1);
  assign frame_start = com_end && (com_idx >= scan_last_i);

  // scan runs regardless of the masks, so timing never moves
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= 13'd0;
      com_idx  <= 3'd0;
    end else if (ce_i && sys_tick_i) begin
      if (com_end) begin
        tick_cnt <= 13'd0; // [RL13]
        com_idx  <= frame_start ? 3'd0 : com_idx + 3'd1; // [RL16]
      end else begin
        tick_cnt <= tick_cnt + 13'd1;
      end
    end
  end

  // ****************************************************************
  // thermal guard
  // ****************************************************************
  logic hot_s1;
  logic hot_s2;
  logic cool_s1;
  logic cool_s2;
  logic ot_flag;

  // comparator pins are asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hot_s1  <= 1'b0;
      hot_s2  <= 1'b0;
      cool_s1 <= 1'b0;
      cool_s2 <= 1'b0;
    end else if (ce_i) begin
      hot_s1  <= temp_hot_i;
      hot_s2  <= hot_s1;
      cool_s1 <= temp_cool_i;
      cool_s2 <= cool_s1;
    end
  end

  // hysteresis flag; hot wins if both are seen at once
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_flag <= 1'b0;
    end else if (ce_i) begin
      if (!mode_act.thermal_guard_enable) begin
        ot_flag <= 1'b0;
      end else if (hot_s2) begin
        ot_flag <= 1'b1; // [RL3] [RL4]
      end else if (cool_s2) begin
        ot_flag <= 1'b0; // [RL3] [RL4]
      end
    end
  end

  // ****************************************************************
  // scrolling
  // ****************************************************************
  logic [7:0] h_frames;
  logic [7:0] v_frames;
  logic       h_run;
  logic       v_run;
  logic       h_due;
  logic       v_due;

  assign h_run = scroll_ctrl.scroll_enable
              && scroll_ctrl.horizontal_scroll_enable;
  assign v_run = scroll_ctrl.scroll_enable
              && scroll_ctrl.vertical_scroll_enable;
  assign h_due = frame_start && h_run
    && (h_frames == frames_last(scroll_speed[SPEED_H_MSB:SPEED_H_LSB]));
  assign v_due = frame_start && v_run
    && (v_frames == frames_last(scroll_speed[SPEED_V_MSB:SPEED_V_LSB]));

  // frame counters restart whenever their axis is off
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      h_frames <= 8'h00;
      v_frames <= 8'h00;
    end else if (ce_i) begin
      if (!h_run || h_due) begin
        h_frames <= 8'h00;
      end else if (frame_start) begin
        h_frames <= h_frames + 8'h01; // [RL12] [RL13]
      end
      if (!v_run || v_due) begin
        v_frames <= 8'h00;
      end else if (frame_start) begin
        v_frames <= v_frames + 8'h01; // [RL12] [RL13]
      end
    end
  end

  // one position per step, direction from the select bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      h_pos_o  <= 5'd0;
      v_pos_o  <= 3'd0;
      h_step_o <= 1'b0;
      v_step_o <= 1'b0;
    end else if (ce_i) begin
      h_step_o <= h_due;
      v_step_o <= v_due;
      if (h_due) begin
        h_pos_o <= row_step(h_pos_o, // [RL10] [RL11]
                            scroll_ctrl.scroll_left_select);
      end
      if (v_due) begin
        // up decrements, down increments; eight lines wrap [RL10] [RL11]
        v_pos_o <= scroll_ctrl.scroll_down_select ? v_pos_o + 3'd1
                                                  : v_pos_o - 3'd1;
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic blank;

  assign blank = mode_act.thermal_guard_enable
              && mode_act.thermal_auto_select && ot_flag;

  // window and thermal blanking; commons scan even when masked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      com_drive_o              <= 8'h00;
      row_enable_o             <= 28'h0000000;
      display_blank_o          <= 1'b0;
      direct_switch_off_o      <= 1'b0;
      over_temperature_flag_o  <= 1'b0;
      first_common_scan_flag_o <= 1'b0;
      frame_start_o            <= 1'b0;
    end else if (ce_i) begin
      com_drive_o  <= blank ? 8'h00
                   : (com_act & (8'h01 << com_idx)); // [RL16] [RL19]
      row_enable_o <= blank ? 28'h0000000 : row_act; // [RL18] [RL19]
      display_blank_o          <= blank; // [RL3]
      direct_switch_off_o      <= blank; // [RL3]
      over_temperature_flag_o  <= ot_flag; // [RL4]
      first_common_scan_flag_o <= (com_idx == 3'd0);
      frame_start_o            <= frame_start;
    end
  end

  // effective function switches after the mode interlocks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      universal_common_function_active_o        <= 1'b0;
      universal_segment_function_active_o        <= 1'b0;
      mask_active_o        <= 1'b0;
      fade_active_o        <= 1'b0;
      group_blink_o        <= 1'b0;
      scroll_down_select_o <= 1'b0;
      scroll_left_select_o <= 1'b0;
    end else if (ce_i) begin
      universal_common_function_active_o <= mode_act.universal_common_enable
                    && !scroll_ctrl.scroll_enable; // [RL6]
      universal_segment_function_active_o <= mode_act.universal_segment_enable
                    && !scroll_ctrl.scroll_enable; // [RL6]
      mask_active_o <= mode_act.matrix_mask_enable && !binary_mode_i; // [RL7]
      fade_active_o <= mode_act.fade_enable && !binary_mode_i; // [RL7]
      group_blink_o <= mode_act.group_blink_enable; // [RL8]
      scroll_down_select_o <= scroll_ctrl.scroll_down_select; // [RL11]
      scroll_left_select_o <= scroll_ctrl.scroll_left_select; // [RL11]
    end
  end

endmodule : lms_mode_scroll_ctrl
`default_nettype wire

// file: testbench/lms_mode_scroll_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lms_ctrl_asserts
  import lms_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // watched signals
  input wire logic        binary_mode_i,
  input wire logic        over_temperature_flag_o,
  input wire logic        display_blank_o,
  input wire logic        direct_switch_off_o,
  input wire logic        frame_start_o,
  input wire logic [7:0]  com_drive_o,
  input wire logic [27:0] row_enable_o,
  input wire logic        mask_active_o,
  input wire logic        fade_active_o,
  input wire logic        h_step_o,
  input wire logic [4:0]  h_pos_o,
  input wire logic [2:0]  v_pos_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [4:0] h_inc;
  logic [4:0] h_dec;
  // neighbours of the offset, wrap at both ends
  always_comb begin
    h_inc = (h_pos_o == ROW_POS_LAST) ? 5'h00 : h_pos_o + 5'h01;
    h_dec = (h_pos_o == 5'h00) ? ROW_POS_LAST : h_pos_o - 5'h01;
  end
  a_blank_from_flag: assert property (
    display_blank_o |-> over_temperature_flag_o)
    else $error("blank without flag");
  a_switch_with_blank: assert property (
    direct_switch_off_o == display_blank_o)
    else $error("direct switch differs from blank");
  a_blank_rows_off: assert property (
    display_blank_o && $past(display_blank_o) |-> row_enable_o == 28'h0)
    else $error("rows lit while blanked");
  a_binary_gates: assert property (
    binary_mode_i [*3] |=> !(mask_active_o || fade_active_o))
    else $error("mask or fade active in binary mode");
  a_com_single: assert property (
    $onehot0(com_drive_o))
    else $error("more than one common driven");
  a_h_one_step: assert property (
    $changed(h_pos_o) |-> h_pos_o == $past(h_inc) || h_pos_o == $past(h_dec))
    else $error("horizontal offset jumped");
  a_v_one_step: assert property (
    $changed(v_pos_o) |-> 3'(v_pos_o - $past(v_pos_o)) inside {3'h1, 3'h7})
    else $error("vertical offset jumped");
  a_frame_gap: assert property (
    frame_start_o |=> !frame_start_o [*8])
    else $error("frame starts too close");
  cp_blank: cover property (display_blank_o);
  cp_hstep: cover property (h_step_o);
  cp_frame: cover property (frame_start_o);
endmodule : lms_ctrl_asserts
bind lms_mode_scroll_ctrl lms_ctrl_asserts u_chk (.clk_i, .reset_n_i,
  .binary_mode_i, .over_temperature_flag_o, .display_blank_o,
  .direct_switch_off_o, .frame_start_o, .com_drive_o, .row_enable_o,
  .mask_active_o, .fade_active_o, .h_step_o, .h_pos_o, .v_pos_o);
`default_nettype wire

// file: testbench/lms_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module lms_host_model
  import lms_pkg::*;
(
  // link towards the device
  output logic       lk_o,
  output logic       start_o,
  output logic       valid_o,
  output logic       ack_o,
  output logic [7:0] byte_o,
  // read return
  input  wire logic [7:0] rd_data_i
);
  logic run = 1'b0;
  initial begin
    {lk_o, start_o, valid_o, ack_o, byte_o} = 12'h000;
  end
  // link clock only runs inside a command, stands low between
  always begin
    #62 lk_o = run;
    #63 lk_o = 1'b0;
  end
  // one byte, released line shows the inverse, 10 link cycles apart;
  // driven just after a link edge so the device never races the change
  task put(input logic s, input logic [7:0] b);
    run = 1'b1;
    @(posedge lk_o);
    #1 {start_o, valid_o, byte_o} = {s, 1'b1, b};
    @(posedge lk_o);
    #1 {start_o, valid_o, byte_o} = {2'b00, ~b};
    repeat (8) @(posedge lk_o);
    #1;
  endtask : put
  // opcode then n bytes, high byte first; fade never set while scrolling
  task cmd(input logic [7:0] op, input logic [2:0] n, input logic [31:0] p);
    int i;
    put(1'b1, op);
    for (i = int'(n) - 1; i >= 0; i--) put(1'b0, p[8*i+:8]);
    run = 1'b0;
  endtask : cmd
  // host polls the flag before switching the display itself
  task rd(output logic [7:0] b0, output logic [7:0] b1);
    put(1'b1, OP_READ_FLAG);
    b0 = rd_data_i;
    ack_o = 1'b1;
    @(posedge lk_o);
    #1 ack_o = 1'b0;
    repeat (4) @(posedge lk_o);
    #1 b1 = rd_data_i;
    run = 1'b0;
  endtask : rd
endmodule : lms_host_model
`default_nettype wire

// file: testbench/tb_led_display_mode_scroll_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_led_display_mode_scroll_control
  import lms_pkg::*;
;
  typedef struct packed {
    logic [7:0] op; logic [2:0] n; logic [31:0] p;
    logic [27:0] row; logic [4:0] md; logic [7:0] com;
  } lms_row_s;
  logic clk_i = 0, reset_n_i = 0, ce_i = 1, sys_tick_i = 1;
  logic binary_mode_i = 0, temp_hot_i = 0, temp_cool_i = 0;
  logic [2:0] scan_last_i = 3'h0;
  logic link_clk_i, link_start_i, link_byte_valid_i, link_rd_ack_i;
  logic [7:0] link_byte_i, link_rd_data_o, com_drive_o, b0, b1;
  logic link_rd_valid_o, over_temperature_flag_o, display_blank_o;
  logic direct_switch_off_o, frame_start_o, first_common_scan_flag_o;
  logic universal_common_function_active_o, universal_segment_function_active_o, mask_active_o, fade_active_o;
  logic group_blink_o, h_step_o, v_step_o;
  logic scroll_down_select_o, scroll_left_select_o;
  logic [27:0] row_enable_o;
  logic [4:0] h_pos_o;
  logic [2:0] v_pos_o;
  int n_errors = 0, checks = 0, cyc = 0, i, k;
  lms_row_s rows [5] = '{
    '{OP_COM_MASK, 3'h1, 32'h3c, 28'h0, 5'h00, 8'h3c},
    '{OP_ROW_MASK, 3'h4, 32'h0fffff00, 28'h0fffff0, 5'h00, 8'h3c},
    '{OP_ROW_MASK, 3'h4, 32'hff, 28'hf, 5'h00, 8'h3c},
    '{OP_MODE_CTRL, 3'h1, 32'h3e, 28'hf, 5'h1d, 8'h3c},
    '{OP_SCROLL_CTRL, 3'h1, 32'hd3, 28'hf, 5'h05, 8'h3c}};
  lms_mode_scroll_ctrl dut (.*);
  lms_host_model host (.lk_o(link_clk_i), .start_o(link_start_i),
    .valid_o(link_byte_valid_i), .ack_o(link_rd_ack_i),
    .byte_o(link_byte_i), .rd_data_i(link_rd_data_o));
  // ******************************
  // clock, timeout, helpers
  // ******************************
  always #2 clk_i = ~clk_i;
  // hang guard, a few frames past the first scroll step
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // wait for a frame start, then let the copies land
  task wait_fs;
    int j;
    for (j = 0; j < 5000 && frame_start_o !== 1'b1; j++) begin
      @(posedge clk_i);
      #1;
    end
    if (j == 5000) n_errors++; // frame start never came
    repeat (3) @(posedge clk_i);
    #1;
  endtask : wait_fs
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // ******************************
  // main sequence
  // ******************************
  initial begin
    repeat (12) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("row_reset", 0, row_enable_o);
    chk("rd_valid_reset", 0, link_rd_valid_o);
    chk("com_reset", 0, com_drive_o);
    for (k = 0; k < 5; k++) begin
      host.cmd(rows[k].op, rows[k].n, rows[k].p);
      wait_fs();
      chk("row_enable", rows[k].row, row_enable_o);
      chk("modes", rows[k].md, {universal_common_function_active_o, universal_segment_function_active_o,
        mask_active_o, fade_active_o, group_blink_o});
      chk("com_window", 0, com_drive_o & ~rows[k].com);
    end
    // binary display drops mask even though its bit is set
    binary_mode_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk("binary_mask", 0, mask_active_o);
    binary_mode_i = 1'b0;
    // auto thermal guard, applied only at the next frame
    wait_fs();
    temp_hot_i = 1'b1;
    host.cmd(OP_MODE_CTRL, 3'h1, 32'hc0);
    chk("blank_early", 0, display_blank_o);
    wait_fs();
    repeat (8) @(posedge clk_i);
    #1 chk("blank_auto", 1, display_blank_o);
    chk("switch_auto", 1, direct_switch_off_o);
    chk("row_blank", 0, row_enable_o);
    host.rd(b0, b1);
    chk("rd_first", 0, b0);
    chk("rd_flag", 1, b1[0]);
    chk("rd_com0", 1, b1[1]);
    chk("first_common_scan_flag", 1, first_common_scan_flag_o);
    chk("rd_valid", 1, link_rd_valid_o);
    // user thermal mode: flag only, no blanking
    host.cmd(OP_MODE_CTRL, 3'h1, 32'h80);
    chk("rd_valid_drop", 0, link_rd_valid_o);
    wait_fs();
    repeat (8) @(posedge clk_i);
    #1 chk("blank_user", 0, display_blank_o);
    chk("flag_user", 1, over_temperature_flag_o);
    {temp_hot_i, temp_cool_i} = 2'b01;
    repeat (8) @(posedge clk_i);
    #1 chk("flag_cool", 0, over_temperature_flag_o);
    // first step of the left scroll, 16 frames after enable
    for (i = 0; i < 70000 && h_step_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("h_step", 1, h_step_o);
    chk("v_step_off", 0, v_step_o);
    repeat (3) @(posedge clk_i);
    #1 chk("h_pos_left", 27, h_pos_o);
    chk("v_pos_still", 0, v_pos_o);
    chk("left_sel", 1, scroll_left_select_o);
    chk("down_sel", 1, scroll_down_select_o);
    tally_and_finish();
  end
endmodule : tb_led_display_mode_scroll_control
`default_nettype wire
